// >>> verilog/wdg_top.sv
// Watchdog with 16-bit period prescaler and shared 8-bit prescaler.
// Assumes all inputs synchronous to clk_i; one-cycle event pulses.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Chain ticks from 31 kHz slow oscillator
// - Dedicated 16-bit period prescaler before time-out
// - 8-bit prescaler shared, one owner at once
// - Periods span 1 ms to 271 s
// - Control register resets to 0x08 always
// - Reset control value gives 17 ms base
// - Stable flag ignores watchdog use of oscillator
// - Startup timer running holds watchdog in reset
// - Startup expiry releases enabled watchdog to count
// - Configuration enable forces continuous running
// - Configuration enable makes software bit ignored
// - Otherwise software bit enables and disables
// - Cleared when disabled, clear, osc fail, wake
// - Crystal wake keeps cleared until startup ends
// - Clear instruction zeroes chain, sets both flags except time-out flag on same-cycle time-out
module wdg_top (
    input  wire logic                  clk_i,
    input  wire logic                  resetn_i,
    input  wire wdg_pkg::wdg_bus_req_t bus_i,
    output logic [7:0]                 rdata_o,
    input  wire logic                  cfg_wdg_en_i,
    input  wire logic                  sys_rst_i,
    input  wire logic                  clear_instr_i,
    input  wire logic                  osc_fail_i,
    input  wire logic                  sleep_i,
    input  wire logic                  wake_i,
    input  wire wdg_pkg::wdg_clk_mode_t clk_mode_i,
    input  wire logic                  startup_busy_i,
    input  wire logic                  lf_run_req_i,
    input  wire logic                  tmr0_src_i,
    output logic                       tmr0_inc_o,
    output logic                       lf_stable_o,
    output logic                       wdg_rst_o,
    output logic                       wdg_wake_o,
    output logic                       timeout_flag_o,
    output logic                       powerdown_flag_o,
    output logic                       irq_o
);
    typedef enum logic [1:0] {
        WS_OFF,
        WS_RUN,
        WS_HOLD
    } wdg_state_t;

    wdg_state_t  state_r, state_nxt;
    logic [11:0] lf_cnt_r, lf_cnt_nxt;
    logic [15:0] pre_r, pre_nxt;
    logic [7:0]  shr_r, shr_nxt;
    logic [7:0]  ctrl_r, ctrl_nxt;
    logic [7:0]  opt_r, opt_nxt;
    logic [1:0]  ist_r, ist_nxt;
    logic [1:0]  imsk_r, imsk_nxt;
    logic [7:0]  rdata_nxt;
    logic        busy_d_r;
    logic        tmo_r, tmo_nxt;
    logic        pwr_r, pwr_nxt;
    logic        rst_nxt, wake_nxt, inc_nxt, irq_nxt;

    logic        lf_tick, wd_en, slow_clk, clr_any, running;
    logic        tap, shr_hit, timeout, assign_wdg;
    logic [3:0]  ratio;
    logic [16:0] tap_mask;
    logic [8:0]  shr_mask;
    logic [3:0]  shr_bits;

    // Slow oscillator emulated as a one-cycle enable
    assign lf_tick = (lf_cnt_r == wdg_pkg::LF_DIV_M1);

    assign wd_en = cfg_wdg_en_i | ctrl_r[wdg_pkg::CTRL_SWEN];

    assign slow_clk = (clk_mode_i == wdg_pkg::WDG_CRYSTAL)
                   || (clk_mode_i == wdg_pkg::WDG_FAST_CRYSTAL)
                   || (clk_mode_i == wdg_pkg::WDG_LOWPWR_CRYSTAL);

    assign running = (state_r == WS_RUN);

    // Period select; reserved codes clamp to the longest period
    always_comb begin
        ratio = ctrl_r[wdg_pkg::CTRL_RHI:wdg_pkg::CTRL_RLO];
        if (ratio > wdg_pkg::RATIO_MAX) begin
            ratio = wdg_pkg::RATIO_MAX;
        end
    end

    // Tap at 2^(select+5) slow ticks, 0x4 gives 512 ticks
    assign tap_mask = (17'h00001 << (5'(ratio) + wdg_pkg::RATIO_BASE))
                    - 17'h00001;
    assign tap = running && lf_tick
              && (&(pre_r | ~tap_mask[15:0]));

    assign assign_wdg = opt_r[wdg_pkg::OPT_ASSIGN];
    // Watchdog owner divides 1:1..1:128, counter owner 1:2..1:256
    assign shr_bits = assign_wdg ? {1'b0, opt_r[2:0]}
                                 : {1'b0, opt_r[2:0]} + 4'h1;
    assign shr_mask = (9'h001 << shr_bits) - 9'h001;
    assign shr_hit  = &(shr_r | ~shr_mask[7:0]);

    assign timeout = assign_wdg ? (tap && shr_hit) : tap;

    // Busy clears at once, the hold state only follows a cycle later
    assign clr_any = !wd_en || clear_instr_i || osc_fail_i
                  || (wake_i && !slow_clk) || timeout
                  || sys_rst_i || !running || startup_busy_i;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            WS_OFF: begin
                if (wd_en && !startup_busy_i) begin
                    state_nxt = WS_RUN;
                end
            end
            WS_RUN: begin
                if (!wd_en) begin
                    state_nxt = WS_OFF;
                end else if (startup_busy_i || (wake_i && slow_clk)) begin
                    state_nxt = WS_HOLD;
                end
            end
            WS_HOLD: begin
                if (!wd_en) begin
                    state_nxt = WS_OFF;
                end else if (busy_d_r && !startup_busy_i) begin
                    state_nxt = WS_RUN;
                end
            end
        endcase
        if (sys_rst_i) begin
            state_nxt = WS_OFF;
        end
    end

    always_comb begin
        lf_cnt_nxt = lf_tick ? 12'h000 : lf_cnt_r + 12'h001;
        pre_nxt = pre_r;
        if (clr_any) begin
            pre_nxt = 16'h0000;
        end else if (lf_tick) begin
            pre_nxt = pre_r + 16'h0001;
        end
        // Only the owner's source steps the shared stage
        shr_nxt = shr_r;
        inc_nxt = 1'b0;
        if (assign_wdg) begin
            inc_nxt = tmr0_src_i;
            if (clr_any) begin
                shr_nxt = 8'h00;
            end else if (tap) begin
                shr_nxt = shr_r + 8'h01;
            end
        end else if (tmr0_src_i) begin
            shr_nxt = shr_r + 8'h01;
            inc_nxt = shr_hit;
        end
    end

    always_comb begin
        tmo_nxt  = tmo_r;
        pwr_nxt  = pwr_r;
        rst_nxt  = timeout && !sleep_i;
        wake_nxt = timeout && sleep_i;
        if (clear_instr_i || sys_rst_i) begin
            tmo_nxt = 1'b1;
            pwr_nxt = 1'b1;
        end
        // Time-out is the cause record, so it wins
        if (timeout) begin
            tmo_nxt = 1'b0;
        end
    end

    always_comb begin
        ctrl_nxt  = ctrl_r;
        opt_nxt   = opt_r;
        imsk_nxt  = imsk_r;
        ist_nxt   = ist_r;
        rdata_nxt = 8'h00;
        if (bus_i.we) begin
            unique case (bus_i.addr)
                wdg_pkg::ADDR_CTRL: ctrl_nxt = {3'h0, bus_i.wdata[4:0]};
                wdg_pkg::ADDR_OPT:  opt_nxt  = {4'h0, bus_i.wdata[3:0]};
                wdg_pkg::ADDR_IMSK: imsk_nxt = bus_i.wdata[1:0];
                default: ;
            endcase
        end
        if (bus_i.re) begin
            unique case (bus_i.addr)
                wdg_pkg::ADDR_CTRL: rdata_nxt = ctrl_r;
                wdg_pkg::ADDR_OPT:  rdata_nxt = opt_r;
                wdg_pkg::ADDR_FLAG: rdata_nxt = {6'h00, tmo_r, pwr_r};
                wdg_pkg::ADDR_IST:  rdata_nxt = {6'h00, ist_r};
                wdg_pkg::ADDR_IMSK: rdata_nxt = {6'h00, imsk_r};
                default:            rdata_nxt = 8'h00;
            endcase
            if (bus_i.addr == wdg_pkg::ADDR_IST) begin
                ist_nxt = 2'h0;
            end
        end
        // New events win over the read clear
        ist_nxt[wdg_pkg::EV_TMO] = ist_nxt[wdg_pkg::EV_TMO] | timeout;
        ist_nxt[wdg_pkg::EV_OSF] = ist_nxt[wdg_pkg::EV_OSF] | osc_fail_i;
        if (sys_rst_i) begin
            ctrl_nxt = wdg_pkg::CTRL_RST;
            opt_nxt  = wdg_pkg::OPT_RST;
        end
        irq_nxt = |(ist_nxt & imsk_nxt);
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r          <= WS_OFF;
            lf_cnt_r         <= 12'h000;
            pre_r            <= 16'h0000;
            shr_r            <= 8'h00;
            ctrl_r           <= wdg_pkg::CTRL_RST;
            opt_r            <= wdg_pkg::OPT_RST;
            ist_r            <= 2'h0;
            imsk_r           <= wdg_pkg::IMSK_RST;
            rdata_o          <= 8'h00;
            busy_d_r         <= 1'b0;
            tmo_r            <= 1'b1;
            pwr_r            <= 1'b1;
            wdg_rst_o        <= 1'b0;
            wdg_wake_o       <= 1'b0;
            tmr0_inc_o       <= 1'b0;
            lf_stable_o      <= 1'b0;
            irq_o            <= 1'b0;
        end else begin
            state_r          <= state_nxt;
            lf_cnt_r         <= lf_cnt_nxt;
            pre_r            <= pre_nxt;
            shr_r            <= shr_nxt;
            ctrl_r           <= ctrl_nxt;
            opt_r            <= opt_nxt;
            ist_r            <= ist_nxt;
            imsk_r           <= imsk_nxt;
            rdata_o          <= rdata_nxt;
            busy_d_r         <= startup_busy_i;
            tmo_r            <= tmo_nxt;
            pwr_r            <= pwr_nxt;
            wdg_rst_o        <= rst_nxt;
            wdg_wake_o       <= wake_nxt;
            tmr0_inc_o       <= inc_nxt;
            // Follows the clock-select request only
            lf_stable_o      <= lf_run_req_i;
            irq_o            <= irq_nxt;
        end
    end

    assign timeout_flag_o   = tmo_r;
    assign powerdown_flag_o = pwr_r;

    // Checks
    tick_space_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        lf_tick |=> !lf_tick [*8])
        else $error("slow tick too frequent");
    startup_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        startup_busy_i |=> (pre_r == 16'h0000))
        else $error("chain counted during startup");
    clear_instr_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        clear_instr_i && !timeout |=> (pre_r == 16'h0000)
        && timeout_flag_o && powerdown_flag_o)
        else $error("clear instruction not applied");
    tmo_reset_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        timeout && !sleep_i |=> wdg_rst_o && !wdg_wake_o
        && !timeout_flag_o)
        else $error("time-out did not reset");
    tmo_wake_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        timeout && sleep_i |=> wdg_wake_o && !wdg_rst_o)
        else $error("time-out did not wake");
    ctrl_reset_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        sys_rst_i |=> ctrl_r == wdg_pkg::CTRL_RST)
        else $error("control not reloaded");
    cfg_force_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        cfg_wdg_en_i && !sys_rst_i && !startup_busy_i && state_r == WS_OFF
        |=> state_r == WS_RUN)
        else $error("forced enable did not run");
    sw_off_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !wd_en |=> state_r == WS_OFF && pre_r == 16'h0000)
        else $error("disabled watchdog kept counting");
    lf_flag_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !lf_run_req_i |=> !lf_stable_o)
        else $error("stable flag followed watchdog use");
    shared_own_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        assign_wdg && $stable(opt_r) && !tap && !clr_any
        |=> $stable(shr_r))
        else $error("shared stage moved by other source");
    ist_read_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        bus_i.re && bus_i.addr == wdg_pkg::ADDR_IST && !timeout
        && !osc_fail_i |=> ist_r == 2'h0 && !irq_o)
        else $error("status read did not clear");

    cov_timeout_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
        wdg_rst_o);
    cov_wake_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
        wdg_wake_o);
    cov_hold_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
        state_r == WS_HOLD ##1 state_r == WS_RUN);
endmodule : wdg_top

`default_nettype wire

// >>> verilog/wdg_pkg.sv
// Constants and carrier types shared by the watchdog block.
// Assumes a single 100 MHz system clock; the slow oscillator is emulated.
`default_nettype none

package wdg_pkg;
    localparam int unsigned CLK_HZ   = 100_000_000;
    localparam int unsigned LFOSC_HZ = 31_000;
    // Longest period fitting the oscillator rate, so rounded down
    localparam int unsigned LF_DIV   = CLK_HZ / LFOSC_HZ;
    localparam logic [11:0] LF_DIV_M1 = 12'(LF_DIV - 1);

    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_OPT  = 4'h1;
    localparam logic [3:0] ADDR_FLAG = 4'h2;
    localparam logic [3:0] ADDR_IST  = 4'h3;
    localparam logic [3:0] ADDR_IMSK = 4'h4;

    localparam logic [7:0] CTRL_RST = 8'h08;
    localparam logic [7:0] OPT_RST  = 8'h0f;
    localparam logic [1:0] IMSK_RST = 2'h0;

    localparam int unsigned CTRL_SWEN = 0;
    localparam int unsigned CTRL_RLO  = 1;
    localparam int unsigned CTRL_RHI  = 4;
    localparam int unsigned OPT_ASSIGN = 3;
    localparam int unsigned FLAG_PWR  = 0;
    localparam int unsigned FLAG_TMO  = 1;
    localparam int unsigned EV_TMO    = 0;
    localparam int unsigned EV_OSF    = 1;

    // Period select 0 is 1:32, largest legal select is 1:65536
    localparam logic [4:0] RATIO_BASE = 5'h05;
    localparam logic [3:0] RATIO_MAX  = 4'hb;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       we;
        logic       re;
    } wdg_bus_req_t;

    typedef enum logic [2:0] {
        WDG_EXT_RC,
        WDG_INT_OSC,
        WDG_EXT_CLK,
        WDG_TMR1_OSC,
        WDG_CRYSTAL,
        WDG_FAST_CRYSTAL,
        WDG_LOWPWR_CRYSTAL
    } wdg_clk_mode_t;
endpackage : wdg_pkg

`default_nettype wire

// >>> dv/wdg_top_bench.sv
// Self-checking bench for the watchdog block: register, prescaler, irq,
// time-out. Assumes the block's 100 MHz clock and fixed slow-tick divider.
`timescale 1ns/100ps
`default_nettype none

module wdg_top_bench;
    logic                   clk_i = 1'b0;
    logic                   resetn_i;
    wdg_pkg::wdg_bus_req_t  bus_i;
    logic [7:0]             rdata_o;
    logic                   cfg_wdg_en_i;
    logic                   sys_rst_i;
    logic                   clear_instr_i;
    logic                   osc_fail_i;
    logic                   sleep_i;
    logic                   wake_i;
    wdg_pkg::wdg_clk_mode_t clk_mode_i;
    logic                   startup_busy_i;
    logic                   lf_run_req_i;
    logic                   tmr0_src_i;
    logic                   tmr0_inc_o;
    logic                   lf_stable_o;
    logic                   wdg_rst_o;
    logic                   wdg_wake_o;
    logic                   timeout_flag_o;
    logic                   powerdown_flag_o;
    logic                   irq_o;
    int                     n_mismatch = 0;
    int                     num_checks = 0;
    int                     n_inc = 0;
    int                     n0;
    int                     cyc;
    // Option values and expected timer_zero increments per 16 source edges
    logic [7:0]             opt_tab [4] = '{8'h00, 8'h01, 8'h02, 8'h08};
    logic [7:0]             inc_tab [4] = '{8'h08, 8'h04, 8'h02, 8'h10};

    wdg_top dut (
        .clk_i            (clk_i),
        .resetn_i         (resetn_i),
        .bus_i            (bus_i),
        .rdata_o          (rdata_o),
        .cfg_wdg_en_i     (cfg_wdg_en_i),
        .sys_rst_i        (sys_rst_i),
        .clear_instr_i    (clear_instr_i),
        .osc_fail_i       (osc_fail_i),
        .sleep_i          (sleep_i),
        .wake_i           (wake_i),
        .clk_mode_i       (clk_mode_i),
        .startup_busy_i   (startup_busy_i),
        .lf_run_req_i     (lf_run_req_i),
        .tmr0_src_i       (tmr0_src_i),
        .tmr0_inc_o       (tmr0_inc_o),
        .lf_stable_o      (lf_stable_o),
        .wdg_rst_o        (wdg_rst_o),
        .wdg_wake_o       (wdg_wake_o),
        .timeout_flag_o   (timeout_flag_o),
        .powerdown_flag_o (powerdown_flag_o),
        .irq_o            (irq_o)
    );

    always #5 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        if (tmr0_inc_o === 1'b1) begin
            n_inc <= n_inc + 1;
        end
    end

    task automatic chk8(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk8

    task automatic chk1(input string nm, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask : chk1

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge clk_i);
        bus_i <= '0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input string nm,
                      input logic [7:0] e);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
        @(posedge clk_i);
        bus_i <= '0;
        #1;
        chk8(nm, e, rdata_o);
    endtask : rd

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cycles

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    // Whole run is one time-out of about 103k cycles plus short tests
    initial begin
        #1_300_000;
        n_mismatch++;
        summarize();
    end

    initial begin
        resetn_i = 1'b0;
        bus_i = '0;
        {cfg_wdg_en_i, sys_rst_i, clear_instr_i, osc_fail_i} = 4'h0;
        {sleep_i, wake_i, startup_busy_i, lf_run_req_i} = 4'h0;
        tmr0_src_i = 1'b0;
        clk_mode_i = wdg_pkg::WDG_INT_OSC;
        repeat (12) @(posedge clk_i);
        resetn_i <= 1'b1;
        cycles(1);
        chk1("timeout flag", 1'b1, timeout_flag_o);
        chk1("irq idle", 1'b0, irq_o);
        rd(wdg_pkg::ADDR_CTRL, "ctrl reset", 8'h08);
        rd(wdg_pkg::ADDR_OPT, "opt reset", 8'h0f);
        rd(wdg_pkg::ADDR_FLAG, "flags reset", 8'h03);
        rd(wdg_pkg::ADDR_IMSK, "mask reset", 8'h00);
        rd(4'h7, "unmapped", 8'h00);
        wr(wdg_pkg::ADDR_CTRL, 8'hff);
        rd(wdg_pkg::ADDR_CTRL, "ctrl high bits", 8'h1f);
        wr(wdg_pkg::ADDR_FLAG, 8'h00);
        rd(wdg_pkg::ADDR_FLAG, "flags read only", 8'h03);
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(wdg_pkg::ADDR_CTRL, "ctrl after reset", 8'h08);
        rd(wdg_pkg::ADDR_OPT, "opt after reset", 8'h0f);
        for (int i = 0; i < 4; i++) begin
            wr(wdg_pkg::ADDR_OPT, opt_tab[i]);
            n0 = n_inc;
            repeat (16) begin
                @(posedge clk_i);
                tmr0_src_i <= 1'b1;
                @(posedge clk_i);
                tmr0_src_i <= 1'b0;
            end
            cycles(4);
            chk8("tmr0 incs", inc_tab[i], 8'(n_inc - n0));
        end
        @(posedge clk_i);
        osc_fail_i <= 1'b1;
        @(posedge clk_i);
        osc_fail_i <= 1'b0;
        cycles(3);
        chk1("irq masked", 1'b0, irq_o);
        wr(wdg_pkg::ADDR_IMSK, 8'h02);
        cycles(3);
        chk1("irq osc fail", 1'b1, irq_o);
        rd(wdg_pkg::ADDR_IST, "status osc fail", 8'h02);
        cycles(3);
        chk1("irq after clear", 1'b0, irq_o);
        rd(wdg_pkg::ADDR_IST, "status cleared", 8'h00);
        // Software bit stays 0: only the configuration enable runs it
        wr(wdg_pkg::ADDR_OPT, 8'h00);
        wr(wdg_pkg::ADDR_CTRL, 8'h00);
        wr(wdg_pkg::ADDR_IMSK, 8'h01);
        @(posedge clk_i);
        cfg_wdg_en_i <= 1'b1;
        @(posedge clk_i);
        clear_instr_i <= 1'b1;
        @(posedge clk_i);
        clear_instr_i <= 1'b0;
        cyc = 0;
        while (wdg_rst_o !== 1'b1 && cyc < 110000) begin
            @(posedge clk_i);
            #1;
            cyc++;
        end
        chk1("time-out reset", 1'b1, wdg_rst_o);
        // 32 slow ticks of 3225 clocks, one tick of phase slack
        chk1("period", 1'b1, cyc >= 99975 && cyc <= 106450);
        chk1("flag on time-out", 1'b0, timeout_flag_o);
        chk1("no wake awake", 1'b0, wdg_wake_o);
        chk1("stable flag", 1'b0, lf_stable_o);
        cycles(1);
        chk1("reset pulse end", 1'b0, wdg_rst_o);
        cycles(2);
        chk1("irq time-out", 1'b1, irq_o);
        rd(wdg_pkg::ADDR_IST, "status time-out", 8'h01);
        // Crystal wake, then start-up busy, park the chain in hold
        @(posedge clk_i);
        clk_mode_i <= wdg_pkg::WDG_CRYSTAL;
        wake_i     <= 1'b1;
        @(posedge clk_i);
        wake_i         <= 1'b0;
        startup_busy_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        startup_busy_i <= 1'b0;
        cycles(2);
        chk1("no reset in hold", 1'b0, wdg_rst_o);
        @(posedge clk_i);
        lf_run_req_i <= 1'b1;
        cfg_wdg_en_i <= 1'b0;
        cycles(2);
        chk1("stable when run", 1'b1, lf_stable_o);
        @(posedge clk_i);
        clear_instr_i <= 1'b1;
        @(posedge clk_i);
        clear_instr_i <= 1'b0;
        cycles(2);
        chk1("flag after clear", 1'b1, timeout_flag_o);
        chk1("pd after clear", 1'b1, powerdown_flag_o);
        rd(wdg_pkg::ADDR_FLAG, "flags after clear", 8'h03);
        summarize();
    end
endmodule : wdg_top_bench

`default_nettype wire
